// >>> core/slffb_bank.sv
`timescale 1ns/1ps
`default_nettype none
module slffb_bank #(
    parameter int RST_SHORT_CYCLES = slffb_pkg::RST_SHORT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmdValid,
    input wire logic [15:0] cmdWord,
    input wire logic auxRegulatorLow,
    input wire logic auxRegulatorOverCurrent,
    input wire logic canSupplyThermal,
    input wire logic canSupplyUnderVoltage,
    input wire logic canSupplyOverCurrent,
    input wire logic senseInputLow,
    input wire logic batterySupplyPinLow,
    input wire logic coreSupplyOverLimit,
    input wire logic coreSupplyOverLpLimit,
    input wire logic normalMode,
    input wire logic lowPowerCoreOn,
    input wire logic coreThermalOff,
    input wire logic resetPinLow,
    input wire logic batteryBelowFail,
    input wire logic [6:0] lin1Faults,
    input wire logic lin1OperatingState,
    input wire logic lin1WakeReceiverEnable,
    input wire logic [6:0] lin2Faults,
    input wire logic lin2OperatingState,
    input wire logic lin2WakeReceiverEnable,
    output logic rspValid,
    output logic [7:0] rspData
);
    localparam int CW = slffb_pkg::RST_CNT_W;
    localparam logic [CW-1:0] RST_LIMIT = CW'(RST_SHORT_CYCLES);

    typedef struct packed {
        logic [7:0] regA;
        logic [7:0] regB;
        logic [6:0] lin1;
        logic [6:0] lin2;
        logic [CW-1:0] lowCnt;
        logic rstLowPrev;
        logic rspValid;
        logic [7:0] rspData;
    } slffb_state_t;

    slffb_state_t st_r;
    slffb_state_t st_nxt;

    logic [slffb_pkg::NUM_FILT-1:0] filtIn;
    logic [slffb_pkg::NUM_FILT-1:0] filtOut;
    logic rdA;
    logic rdB;
    logic rdLin1;
    logic rdLin2;
    logic rdStat1;
    logic rdStat2;
    logic shortPulseEnd;

    // Filtered sources; core overcurrent qualified by the active mode
    assign filtIn[slffb_pkg::F_AUX_LOW] = auxRegulatorLow;
    assign filtIn[slffb_pkg::F_AUX_OC] = auxRegulatorOverCurrent;
    assign filtIn[slffb_pkg::F_CAN_UV] = canSupplyUnderVoltage;
    assign filtIn[slffb_pkg::F_CAN_OC] = canSupplyOverCurrent;
    assign filtIn[slffb_pkg::F_SENSE] = senseInputLow;
    assign filtIn[slffb_pkg::F_BAT_UV] = batterySupplyPinLow;
    assign filtIn[slffb_pkg::F_CORE_OC] = coreSupplyOverLimit & normalMode;
    assign filtIn[slffb_pkg::F_CORE_OC_LP] =
        coreSupplyOverLpLimit & lowPowerCoreOn;

    // One hold filter per filtered source
    for (genvar i = 0; i < slffb_pkg::NUM_FILT; i++) begin : gFilt
        slffb_hold_filter #(
            .CYCLES(slffb_pkg::FILTER_CYCLES)
        ) uFilt (
            .clk(clk),
            .rst(rst),
            .level(filtIn[i]),
            .qualified(filtOut[i])
        );
    end

    // Command decode
    assign rdA = cmdValid && (cmdWord == slffb_pkg::CMD_REG_A);
    assign rdB = cmdValid && (cmdWord == slffb_pkg::CMD_REG_B);
    assign rdLin1 = cmdValid && (cmdWord == slffb_pkg::CMD_LIN1_FLAGS);
    assign rdLin2 = cmdValid && (cmdWord == slffb_pkg::CMD_LIN2_FLAGS);
    assign rdStat1 = cmdValid && (cmdWord == slffb_pkg::CMD_LIN1_STATUS);
    assign rdStat2 = cmdValid && (cmdWord == slffb_pkg::CMD_LIN2_STATUS);

    // Reset pin released before the long-low limit was reached
    assign shortPulseEnd = st_r.rstLowPrev && !resetPinLow &&
        (st_r.lowCnt < RST_LIMIT);

    // Set beats clear; a read clears only once the cause is gone
    function automatic logic flagUpd(input logic flag, input logic setNow,
            input logic active, input logic rdClr);
        return setNow | (flag & ~(rdClr & ~active));
    endfunction

    always_comb begin
        st_nxt = st_r;
        st_nxt.rstLowPrev = resetPinLow;
        // Saturate so a very long low never wraps into a false short
        if (!resetPinLow) begin
            st_nxt.lowCnt = '0;
        end else if (st_r.lowCnt != RST_LIMIT) begin
            st_nxt.lowCnt = st_r.lowCnt + 1'b1;
        end

        // Bank A
        st_nxt.regA[slffb_pkg::AUX_LOW_BIT] = flagUpd(
            st_r.regA[slffb_pkg::AUX_LOW_BIT], filtOut[slffb_pkg::F_AUX_LOW],
            auxRegulatorLow, rdA);
        st_nxt.regA[slffb_pkg::AUX_OC_BIT] = flagUpd(
            st_r.regA[slffb_pkg::AUX_OC_BIT], filtOut[slffb_pkg::F_AUX_OC],
            auxRegulatorOverCurrent, rdA);
        st_nxt.regA[slffb_pkg::CAN_THERM_BIT] = flagUpd(
            st_r.regA[slffb_pkg::CAN_THERM_BIT], canSupplyThermal,
            canSupplyThermal, rdA);
        st_nxt.regA[slffb_pkg::CAN_UV_BIT] = flagUpd(
            st_r.regA[slffb_pkg::CAN_UV_BIT], filtOut[slffb_pkg::F_CAN_UV],
            canSupplyUnderVoltage, rdA);
        st_nxt.regA[slffb_pkg::CAN_OC_BIT] = flagUpd(
            st_r.regA[slffb_pkg::CAN_OC_BIT], filtOut[slffb_pkg::F_CAN_OC],
            canSupplyOverCurrent, rdA);
        st_nxt.regA[slffb_pkg::SENSE_LOW_BIT] = flagUpd(
            st_r.regA[slffb_pkg::SENSE_LOW_BIT], filtOut[slffb_pkg::F_SENSE],
            senseInputLow, rdA);
        st_nxt.regA[slffb_pkg::BAT_UV_BIT] = flagUpd(
            st_r.regA[slffb_pkg::BAT_UV_BIT], filtOut[slffb_pkg::F_BAT_UV],
            batterySupplyPinLow, rdA);
        st_nxt.regA[slffb_pkg::CORE_OC_BIT] = flagUpd(
            st_r.regA[slffb_pkg::CORE_OC_BIT], filtOut[slffb_pkg::F_CORE_OC],
            filtIn[slffb_pkg::F_CORE_OC], rdA);

        // Bank B, unused bits stay zero
        st_nxt.regB[slffb_pkg::CORE_THERM_BIT] = flagUpd(
            st_r.regB[slffb_pkg::CORE_THERM_BIT], coreThermalOff,
            coreThermalOff, rdB);
        st_nxt.regB[slffb_pkg::RST_SHORT_BIT] = flagUpd(
            st_r.regB[slffb_pkg::RST_SHORT_BIT], shortPulseEnd,
            resetPinLow, rdB);
        st_nxt.regB[slffb_pkg::BAT_FAIL_BIT] = flagUpd(
            st_r.regB[slffb_pkg::BAT_FAIL_BIT], batteryBelowFail,
            batteryBelowFail, rdB);
        st_nxt.regB[slffb_pkg::CORE_OC_LP_BIT] = flagUpd(
            st_r.regB[slffb_pkg::CORE_OC_LP_BIT],
            filtOut[slffb_pkg::F_CORE_OC_LP],
            filtIn[slffb_pkg::F_CORE_OC_LP], rdB);

        // LIN flags follow the same set-wins, clear-on-read scheme
        st_nxt.lin1 = lin1Faults |
            (st_r.lin1 & ~({slffb_pkg::LIN_FLAG_W{rdLin1}} & ~lin1Faults));
        st_nxt.lin2 = lin2Faults |
            (st_r.lin2 & ~({slffb_pkg::LIN_FLAG_W{rdLin2}} & ~lin2Faults));

        // Answer carries the value held before this read's clear
        st_nxt.rspValid = cmdValid;
        st_nxt.rspData = slffb_pkg::RSP_IDLE;
        if (rdA) begin
            st_nxt.rspData = st_r.regA;
        end else if (rdB) begin
            st_nxt.rspData = st_r.regB;
        end else if (rdLin1) begin
            st_nxt.rspData = {1'b0, st_r.lin1};
        end else if (rdLin2) begin
            st_nxt.rspData = {1'b0, st_r.lin2};
        end else if (rdStat1) begin
            st_nxt.rspData[slffb_pkg::LIN_STATE_BIT] = lin1OperatingState;
            st_nxt.rspData[slffb_pkg::LIN_WAKE_EN_BIT] =
                lin1WakeReceiverEnable;
        end else if (rdStat2) begin
            st_nxt.rspData[slffb_pkg::LIN_STATE_BIT] = lin2OperatingState;
            st_nxt.rspData[slffb_pkg::LIN_WAKE_EN_BIT] =
                lin2WakeReceiverEnable;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.regA <= slffb_pkg::FLAGS_RESET;
            st_r.regB <= slffb_pkg::FLAGS_RESET;
            st_r.rspData <= slffb_pkg::RSP_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rspValid = st_r.rspValid;
    assign rspData = st_r.rspData;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_AUX_LOW_SET: assert property (
        filtOut[slffb_pkg::F_AUX_LOW] |=> st_r.regA[slffb_pkg::AUX_LOW_BIT])
        else $error("aux low flag not set after filter");
    AST_AUX_LOW_KEEP: assert property (
        st_r.regA[slffb_pkg::AUX_LOW_BIT] && auxRegulatorLow
        |=> st_r.regA[slffb_pkg::AUX_LOW_BIT])
        else $error("aux low flag cleared while fault present");
    AST_AUX_OC_CLEAR: assert property (
        rdA && !auxRegulatorOverCurrent && !filtOut[slffb_pkg::F_AUX_OC]
        |=> !st_r.regA[slffb_pkg::AUX_OC_BIT])
        else $error("aux overcurrent flag not cleared by read");
    AST_CAN_THERM: assert property (
        canSupplyThermal |=> st_r.regA[slffb_pkg::CAN_THERM_BIT])
        else $error("can thermal flag not latched");
    AST_CORE_OC_MODE: assert property (
        $rose(st_r.regA[slffb_pkg::CORE_OC_BIT]) |-> $past(normalMode))
        else $error("core overcurrent set outside normal mode");
    AST_RST_SHORT: assert property (
        (st_r.lowCnt == '0 && resetPinLow) ##1 resetPinLow[*2]
        ##1 !resetPinLow |=> st_r.regB[slffb_pkg::RST_SHORT_BIT])
        else $error("short reset pulse not flagged");
    AST_BAT_FAIL: assert property (
        batteryBelowFail |=> st_r.regB[slffb_pkg::BAT_FAIL_BIT])
        else $error("battery fail flag not set");
    AST_LIN1_STATUS: assert property (
        rdStat1 |=> rspValid && rspData == {$past(lin1OperatingState),
        $past(lin1WakeReceiverEnable), 6'h00})
        else $error("lin1 status answer wrong");
    AST_STATUS_KEEPS: assert property (
        (rdStat1 || rdStat2) |=> ((st_r.lin1 & $past(st_r.lin1)) ==
        $past(st_r.lin1)) && ((st_r.lin2 & $past(st_r.lin2)) ==
        $past(st_r.lin2)))
        else $error("status read changed flags");
    AST_LIN1_FLAGS: assert property (
        rdLin1 |=> rspValid && rspData == {1'b0, $past(st_r.lin1)})
        else $error("lin1 flag answer wrong");
    AST_LIN2_FLAGS: assert property (
        rdLin2 ##1 !cmdValid |-> rspData == {1'b0, $past(st_r.lin2)}
        ##1 !rspValid)
        else $error("lin2 flag answer wrong");

    COV_AUX_LOW_READ: cover property (
        st_r.regA[slffb_pkg::AUX_LOW_BIT] && rdA && !auxRegulatorLow);
    COV_SHORT_PULSE: cover property ($rose(
        st_r.regB[slffb_pkg::RST_SHORT_BIT]));
    COV_LIN2_STATUS: cover property (rdStat2 && lin2OperatingState);
endmodule // slffb_bank
`default_nettype wire

// >>> core/slffb_hold_filter.sv
`timescale 1ns/1ps
`default_nettype none
module slffb_hold_filter #(
    parameter int CYCLES = slffb_pkg::FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    output logic qualified
);
    localparam int W = slffb_pkg::FILT_CNT_W;
    localparam logic [W-1:0] LIMIT = W'(CYCLES);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic q;
    } slffb_filt_t;

    slffb_filt_t st_r;
    slffb_filt_t st_nxt;

    // Count while the fault persists; any gap restarts the count
    always_comb begin
        st_nxt = st_r;
        if (!level) begin
            st_nxt.cnt = '0;
            st_nxt.q = 1'b0;
        end else if (st_r.cnt == LIMIT) begin
            st_nxt.q = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign qualified = st_r.q;

    // A fault gone means the qualified output drops next cycle
    AST_FILT_DROP: assert property (@(posedge clk) disable iff (rst)
        !level |=> !qualified)
        else $error("filter held after fault ended");
endmodule // slffb_hold_filter
`default_nettype wire

// >>> core/slffb_pkg.sv
// What this block does
// - Aux regulator low after 100 us, read-clear
// - Aux overcurrent after 100 us, read-clear
// - CAN supply thermal latched, read-clear
// - CAN supply undervoltage after 100 us
// - CAN supply overcurrent after 100 us
// - Sense input low after 100 us
// - Battery undervoltage after 100 us
// - Core overcurrent in Normal mode only
// - Core thermal shutdown latched, read-clear
// - Reset pin low under 100 ms flagged
// - Battery fail flag latched, read-clear
// - Low-power core-on overcurrent separate flag
// - LIN1 status: state bit7, wake bit6
// - Live status reads never change anything
`default_nettype none
package slffb_pkg;
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int FILTER_TIME_US = 100;
    localparam int FILTER_CYCLES = FILTER_TIME_US * (CLK_HZ / 1_000_000);
    localparam int FILT_CNT_W = 12;
    localparam int RST_SHORT_TIME_MS = 100;
    localparam int RST_SHORT_CYCLES = RST_SHORT_TIME_MS * (CLK_HZ / 1000);
    localparam int RST_CNT_W = 22;

    // Command word fields: op, register offset, read, bank select
    localparam logic [1:0] OP_FLAGS = 2'h3;
    localparam logic [1:0] OP_STATUS = 2'h0;
    localparam logic [4:0] ADDR_REG = 5'h0f;
    localparam logic [4:0] ADDR_LIN1 = 5'h13;
    localparam logic [4:0] ADDR_LIN2 = 5'h14;
    localparam logic [15:0] CMD_REG_A = {OP_FLAGS, ADDR_REG, 9'h100};
    localparam logic [15:0] CMD_REG_B = {OP_FLAGS, ADDR_REG, 9'h180};
    localparam logic [15:0] CMD_LIN1_FLAGS = {OP_FLAGS, ADDR_LIN1, 9'h100};
    localparam logic [15:0] CMD_LIN1_STATUS = {OP_STATUS, ADDR_LIN1, 9'h180};
    localparam logic [15:0] CMD_LIN2_FLAGS = {OP_FLAGS, ADDR_LIN2, 9'h100};
    localparam logic [15:0] CMD_LIN2_STATUS = {OP_STATUS, ADDR_LIN2, 9'h180};

    // Regulator flag bank A bit positions
    localparam int AUX_LOW_BIT = 7;
    localparam int AUX_OC_BIT = 6;
    localparam int CAN_THERM_BIT = 5;
    localparam int CAN_UV_BIT = 4;
    localparam int CAN_OC_BIT = 3;
    localparam int SENSE_LOW_BIT = 2;
    localparam int BAT_UV_BIT = 1;
    localparam int CORE_OC_BIT = 0;
    // Regulator flag bank B bit positions
    localparam int CORE_THERM_BIT = 4;
    localparam int RST_SHORT_BIT = 2;
    localparam int BAT_FAIL_BIT = 1;
    localparam int CORE_OC_LP_BIT = 0;
    // LIN flag bit positions, bit 7 reads zero
    localparam int LIN_WAKE_BIT = 6;
    localparam int LIN_TERM_GND_BIT = 5;
    localparam int LIN_OVERTEMP_BIT = 4;
    localparam int RX_STUCK_LOW_BIT = 3;
    localparam int RX_STUCK_HIGH_BIT = 2;
    localparam int TX_DOMINANT_BIT = 1;
    localparam int BUS_CLAMP_BIT = 0;
    localparam int LIN_FLAG_W = 7;
    // LIN live status bit positions
    localparam int LIN_STATE_BIT = 7;
    localparam int LIN_WAKE_EN_BIT = 6;

    // Filter channel indices
    localparam int NUM_FILT = 8;
    localparam int F_AUX_LOW = 0;
    localparam int F_AUX_OC = 1;
    localparam int F_CAN_UV = 2;
    localparam int F_CAN_OC = 3;
    localparam int F_SENSE = 4;
    localparam int F_BAT_UV = 5;
    localparam int F_CORE_OC = 6;
    localparam int F_CORE_OC_LP = 7;

    // Reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] RSP_IDLE = 8'h00;
endpackage
`default_nettype wire

// >>> testbench/slffb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module slffb_host_model (
    input wire logic clk,
    output logic cmdValid,
    output logic [15:0] cmdWord,
    input wire logic rspValid,
    input wire logic [7:0] rspData
);
    // Idle host: no command on the port
    initial begin
        cmdValid = 1'b0;
        cmdWord = 16'h0000;
    end

    // Whole command word in one cycle, answer taken one cycle later
    task automatic xfer(input logic [15:0] w, output logic v,
            output logic [7:0] d);
        @(negedge clk);
        cmdValid = 1'b1;
        cmdWord = w;
        @(negedge clk);
        v = rspValid;
        d = rspData;
        cmdValid = 1'b0;
        // Released word lines carry the inverted word, so a stale word cannot match
        cmdWord = ~w;
    endtask
endmodule // slffb_host_model
`default_nettype wire

// >>> testbench/tb_supply_lin_fault_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
module tb_supply_lin_fault_flag_bank;
    localparam int RSTS = 20;
    logic clk, rst, cmdValid, rspValid;
    logic [15:0] cmdWord;
    logic [7:0] rspData;
    logic auxLow, auxOc, canTherm, canUv, canOc, senseLow, batUv, coreOc;
    logic coreOcLowPwr, normalMode, lowPwrOn, coreTherm, rstPinLow, battery_fail_flag;
    logic [6:0] l1F, l2F;
    logic l1S, l1W, l2S, l2W;
    int cntA[8];
    int lowLen, cntLp, fails, checked, seed;
    logic [7:0] mA, mB, mL1, mL2, cA, qA, holdB, setB;
    logic [7:0] expQ[$];
    logic [15:0] cmds[7] = '{slffb_pkg::CMD_REG_A, slffb_pkg::CMD_REG_B,
        slffb_pkg::CMD_LIN1_FLAGS, slffb_pkg::CMD_LIN1_STATUS,
        slffb_pkg::CMD_LIN2_FLAGS, slffb_pkg::CMD_LIN2_STATUS, 16'h1234};

    slffb_bank #(.RST_SHORT_CYCLES(RSTS)) DUT (.clk(clk), .rst(rst),
        .cmdValid(cmdValid), .cmdWord(cmdWord), .auxRegulatorLow(auxLow),
        .auxRegulatorOverCurrent(auxOc), .canSupplyThermal(canTherm),
        .canSupplyUnderVoltage(canUv), .canSupplyOverCurrent(canOc),
        .senseInputLow(senseLow), .batterySupplyPinLow(batUv),
        .coreSupplyOverLimit(coreOc), .coreSupplyOverLpLimit(coreOcLowPwr),
        .normalMode(normalMode), .lowPowerCoreOn(lowPwrOn),
        .coreThermalOff(coreTherm), .resetPinLow(rstPinLow),
        .batteryBelowFail(battery_fail_flag), .lin1Faults(l1F),
        .lin1OperatingState(l1S), .lin1WakeReceiverEnable(l1W),
        .lin2Faults(l2F), .lin2OperatingState(l2S),
        .lin2WakeReceiverEnable(l2W), .rspValid(rspValid),
        .rspData(rspData));

    slffb_host_model host (.clk(clk), .cmdValid(cmdValid),
        .cmdWord(cmdWord), .rspValid(rspValid), .rspData(rspData));

    // Reference flags; a read hands out the old value, then set wins
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {mA, mB, mL1, mL2} = '0;
            foreach (cntA[i]) cntA[i] = 0;
            lowLen = 0;
            cntLp = 0;
            expQ.delete();
        end else begin
            cA = {auxLow, auxOc, canTherm, canUv, canOc, senseLow, batUv,
                coreOc & normalMode};
            foreach (cntA[i]) begin
                cntA[i] = cA[i] ? cntA[i] + 1 : 0;
                qA[i] = cA[i] && (i == 5 ||
                    cntA[i] > slffb_pkg::FILTER_CYCLES + 1);
            end
            holdB = {3'h0, coreTherm, 1'b0, rstPinLow, battery_fail_flag,
                coreOcLowPwr & lowPwrOn};
            // Low-power core current is filtered like the bank A sources
            cntLp = holdB[0] ? cntLp + 1 : 0;
            setB = holdB;
            setB[0] = holdB[0] && cntLp > slffb_pkg::FILTER_CYCLES + 1;
            setB[2] = !rstPinLow && lowLen > 0 && lowLen < RSTS;
            lowLen = rstPinLow ? lowLen + 1 : 0;
            if (cmdValid) begin
                case (cmdWord)
                    cmds[0]: begin
                        expQ.push_back(mA);
                        mA &= cA;
                    end
                    cmds[1]: begin
                        expQ.push_back(mB);
                        mB &= holdB;
                    end
                    cmds[2]: begin
                        expQ.push_back(mL1);
                        mL1 &= {1'b0, l1F};
                    end
                    cmds[3]: expQ.push_back({l1S, l1W, 6'h00});
                    cmds[4]: begin
                        expQ.push_back(mL2);
                        mL2 &= {1'b0, l2F};
                    end
                    cmds[5]: expQ.push_back({l2S, l2W, 6'h00});
                    default: expQ.push_back(8'h00);
                endcase
            end
            mA |= qA;
            mB |= setB;
            mL1 |= {1'b0, l1F};
            mL2 |= {1'b0, l2F};
        end
    end

    task automatic check(input string what, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Every answer is compared with the reference queue
    task automatic readAll();
        logic v;
        logic [7:0] d, e;
        for (int i = 0; i < 7; i++) begin
            host.xfer(cmds[i], v, d);
            e = expQ.size() > 0 ? expQ.pop_front() : 8'hxx;
            check($sformatf("valid%0d", i), {7'h0, v}, 8'h01);
            check($sformatf("cmd%0d", i), d, e);
        end
    endtask

    task automatic setFilt(input logic [7:0] m);
        {auxLow, auxOc, canUv, canOc, senseLow, batUv, coreOc} = m[7:1];
        coreOcLowPwr = m[0];
    endtask

    task automatic summarize();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Hang guard, well above the expected run length
    initial begin
        #(60000 * 40);
        fails++;
        summarize();
    end

    initial begin
        seed = 32541;
        fails = 0;
        checked = 0;
        rst = 1'b1;
        {auxLow, auxOc, canTherm, canUv, canOc, senseLow, batUv} = '0;
        {coreOc, coreOcLowPwr, normalMode, lowPwrOn, coreTherm} = '0;
        {rstPinLow, battery_fail_flag, l1F, l2F, l1S, l1W, l2S, l2W} = '0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        readAll();
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            l1F = 7'($random(seed));
            l2F = 7'($random(seed));
            {l1S, l1W, l2S, l2W} = 4'($random(seed));
            @(negedge clk);
            l1F = 7'($random(seed));
            l2F = 7'($random(seed));
            readAll();
            readAll();
        end
        // Conditions shorter than the filter must leave no trace, longer ones latch
        {normalMode, lowPwrOn} = 2'h3;
        setFilt(8'hff);
        repeat (2000) @(negedge clk);
        setFilt(8'h00);
        readAll();
        setFilt(8'hff);
        repeat (2600) @(negedge clk);
        readAll();
        setFilt(8'h00);
        readAll();
        readAll();
        // Core current flags gated by mode, random mix of sources
        {normalMode, lowPwrOn} = 2'h0;
        setFilt(8'($random(seed)) | 8'h01);
        repeat (2600) @(negedge clk);
        setFilt(8'h00);
        readAll();
        readAll();
        // Unfiltered events latch after a single sample
        {canTherm, coreTherm, battery_fail_flag} = 3'h7;
        @(negedge clk);
        {canTherm, coreTherm, battery_fail_flag} = 3'h0;
        readAll();
        readAll();
        {canTherm, coreTherm, battery_fail_flag} = 3'h7;
        readAll();
        {canTherm, coreTherm, battery_fail_flag} = 3'h0;
        readAll();
        // Short pulse flags, read while pin low keeps it, long does not
        rstPinLow = 1'b1;
        repeat (5) @(negedge clk);
        rstPinLow = 1'b0;
        repeat (2) @(negedge clk);
        rstPinLow = 1'b1;
        readAll();
        repeat (40) @(negedge clk);
        rstPinLow = 1'b0;
        readAll();
        readAll();
        // Reset in mid-run wipes latched flags
        canTherm = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        {rst, canTherm} = 2'h0;
        readAll();
        summarize();
    end
endmodule // tb_supply_lin_fault_flag_bank
`default_nettype wire
